// ==== verilog/sdram_bank_fsm.sv ====
`include "sdram_bank_map.svh"
module sdram_bank_fsm (
  // Clock and reset
  input wire logic clock_in,
  input wire logic arst_n_in,
  // Command pins
  input wire logic cs_n_in,
  input wire logic ras_n_in,
  input wire logic cas_n_in,
  input wire logic we_n_in,
  input wire logic bank_sel_in,
  input wire logic a10_in,
  input wire logic [`COL_W-1:0] col_in,
  // Bank states
  output sdram_pkg::bank_state_t bank0_state_out,
  output sdram_pkg::bank_state_t bank1_state_out,
  // Burst beats
  output logic read_beat_out,
  output logic write_beat_out,
  output logic beat_bank_out,
  output logic [`COL_W-1:0] beat_col_out,
  // Command refused
  output logic illegal_out
);
  localparam logic [3:0] PRE_LOAD = 4'(`PRECHARGE_CYC - 1);
  localparam logic [3:0] WR_LOAD = 4'(`WRITE_RECOVERY_CYC - 1);

  cmd_if cmd ();

  cmd_decode u_decode (
    .cs_n_in(cs_n_in),
    .ras_n_in(ras_n_in),
    .cas_n_in(cas_n_in),
    .we_n_in(we_n_in),
    .bank_sel_in(bank_sel_in),
    .a10_in(a10_in),
    .col_in(col_in),
    .bus(cmd.dec)
  );

  sdram_pkg::bank_state_t state [2];
  sdram_pkg::bank_state_t next_state [2];
  logic [3:0] timer [2];
  logic [3:0] next_timer [2];
  logic autoclose [2];
  logic next_autoclose [2];
  logic [3:0] left;
  logic [3:0] next_left;
  logic next_read_beat;
  logic next_write_beat;
  logic next_beat_bank;
  logic [`COL_W-1:0] next_beat_col;
  logic next_illegal;
  logic tgt;
  logic bursting;

  // Bursting states of a bank
  function automatic logic in_burst(sdram_pkg::bank_state_t st);
    return st == sdram_pkg::ST_READ || st == sdram_pkg::ST_WRITE ||
           st == sdram_pkg::ST_READ_AC;
  endfunction

  // Where a burst lands when it runs out or another bank takes the bus
  function automatic sdram_pkg::bank_state_t burst_end(
      sdram_pkg::bank_state_t st);
    case (st)
      sdram_pkg::ST_WRITE: return sdram_pkg::ST_WRITE_RECOVERY;
      sdram_pkg::ST_READ_AC: return sdram_pkg::ST_PRECHARGE;
      default: return sdram_pkg::ST_ROW_ACTIVE;
    endcase
  endfunction

  // Commands the controller must not give in the target's state or the other bank's
  function automatic logic refused(sdram_pkg::cmd_kind_t k,
      sdram_pkg::bank_state_t st, sdram_pkg::bank_state_t oth);
    case (k)
      sdram_pkg::CMD_ROW_OPEN: return st != sdram_pkg::ST_IDLE;
      sdram_pkg::CMD_READ, sdram_pkg::CMD_READ_AC,
      sdram_pkg::CMD_WRITE, sdram_pkg::CMD_WRITE_AC:
        return !(st == sdram_pkg::ST_ROW_ACTIVE ||
                 st == sdram_pkg::ST_READ || st == sdram_pkg::ST_WRITE ||
                 st == sdram_pkg::ST_WRITE_RECOVERY);
      sdram_pkg::CMD_HALT, sdram_pkg::CMD_CLOSE:
        return st == sdram_pkg::ST_READ_AC;
      sdram_pkg::CMD_CLOSE_ALL:
        return st == sdram_pkg::ST_READ_AC || oth == sdram_pkg::ST_READ_AC;
      sdram_pkg::CMD_REFRESH, sdram_pkg::CMD_MODE:
        return st != sdram_pkg::ST_IDLE || oth != sdram_pkg::ST_IDLE;
      default: return 1'b0;
    endcase
  endfunction

  // Halt has no bank address, so it aims at the bank holding the bus
  assign tgt = (cmd.kind == sdram_pkg::CMD_HALT) ? beat_bank_out
                                                 : cmd.bank;
  assign bursting = in_burst(state[beat_bank_out]);

  // Next bank states, burst progress and command response
  always_comb begin
    next_state = state;
    next_timer = timer;
    next_autoclose = autoclose;
    next_left = left;
    next_read_beat = 1'b0;
    next_write_beat = 1'b0;
    next_beat_bank = beat_bank_out;
    next_beat_col = beat_col_out;
    next_illegal = 1'b0;
    // Timed states count down, then settle
    for (int b = 0; b < 2; b++) begin
      if (state[b] == sdram_pkg::ST_PRECHARGE ||
          state[b] == sdram_pkg::ST_WRITE_RECOVERY) begin
        if (timer[b] != 4'h0) begin
          next_timer[b] = timer[b] - 4'h1;
        end else if (state[b] == sdram_pkg::ST_PRECHARGE) begin
          next_state[b] = sdram_pkg::ST_IDLE;
        end else if (autoclose[b]) begin
          next_state[b] = sdram_pkg::ST_PRECHARGE;
          next_timer[b] = PRE_LOAD;
        end else begin
          next_state[b] = sdram_pkg::ST_ROW_ACTIVE;
        end
      end
    end
    // Running burst delivers a beat per cycle until it runs out
    if (bursting) begin
      if (left != 4'h0) begin
        next_left = left - 4'h1;
        next_beat_col = beat_col_out + `COL_W'(1);
        next_read_beat = state[beat_bank_out] != sdram_pkg::ST_WRITE;
        next_write_beat = state[beat_bank_out] == sdram_pkg::ST_WRITE;
      end else begin
        next_state[beat_bank_out] = burst_end(state[beat_bank_out]);
        next_timer[beat_bank_out] =
          (state[beat_bank_out] == sdram_pkg::ST_WRITE) ? WR_LOAD
                                                        : PRE_LOAD;
      end
    end
    // Illegal commands are flagged and otherwise ignored
    if (refused(cmd.kind, state[tgt], state[!tgt])) begin
      next_illegal = 1'b1;
    end else begin
      case (cmd.kind)
        sdram_pkg::CMD_HALT: begin
          if (bursting) begin
            next_state[beat_bank_out] = sdram_pkg::ST_ROW_ACTIVE;
            next_read_beat = 1'b0;
            next_write_beat = 1'b0;
          end
        end
        sdram_pkg::CMD_READ, sdram_pkg::CMD_READ_AC,
        sdram_pkg::CMD_WRITE, sdram_pkg::CMD_WRITE_AC: begin
          // One data bus: a burst on the other bank gives way
          if (bursting && beat_bank_out != tgt) begin
            next_state[beat_bank_out] = burst_end(state[beat_bank_out]);
            next_timer[beat_bank_out] =
              (state[beat_bank_out] == sdram_pkg::ST_WRITE) ? WR_LOAD
                                                            : PRE_LOAD;
          end
          case (cmd.kind)
            sdram_pkg::CMD_READ: next_state[tgt] = sdram_pkg::ST_READ;
            sdram_pkg::CMD_READ_AC: next_state[tgt] = sdram_pkg::ST_READ_AC;
            default: next_state[tgt] = sdram_pkg::ST_WRITE;
          endcase
          next_autoclose[tgt] = cmd.kind == sdram_pkg::CMD_WRITE_AC;
          next_beat_bank = tgt;
          next_beat_col = cmd.col;
          next_left = `BURST_LEN - 4'h1;
          next_read_beat = cmd.kind == sdram_pkg::CMD_READ ||
                           cmd.kind == sdram_pkg::CMD_READ_AC;
          next_write_beat = !next_read_beat;
        end
        sdram_pkg::CMD_ROW_OPEN: begin
          next_state[tgt] = sdram_pkg::ST_ROW_ACTIVE;
        end
        sdram_pkg::CMD_CLOSE, sdram_pkg::CMD_CLOSE_ALL: begin
          for (int b = 0; b < 2; b++) begin
            if ((cmd.kind == sdram_pkg::CMD_CLOSE_ALL || b == int'(tgt)) &&
                state[b] != sdram_pkg::ST_IDLE) begin
              next_state[b] = sdram_pkg::ST_PRECHARGE;
              next_timer[b] = PRE_LOAD;
              next_autoclose[b] = 1'b0;
              if (b == int'(beat_bank_out)) begin
                next_read_beat = 1'b0;
                next_write_beat = 1'b0;
              end
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Register everything; outputs come from these flops
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= '{sdram_pkg::ST_IDLE, sdram_pkg::ST_IDLE};
      timer <= '{4'h0, 4'h0};
      autoclose <= '{1'b0, 1'b0};
      left <= 4'h0;
      read_beat_out <= 1'b0;
      write_beat_out <= 1'b0;
      beat_bank_out <= 1'b0;
      beat_col_out <= `COL_W'(0);
      illegal_out <= 1'b0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      autoclose <= next_autoclose;
      left <= next_left;
      read_beat_out <= next_read_beat;
      write_beat_out <= next_write_beat;
      beat_bank_out <= next_beat_bank;
      beat_col_out <= next_beat_col;
      illegal_out <= next_illegal;
    end
  end

  assign bank0_state_out = state[0];
  assign bank1_state_out = state[1];

  // Checks on the burst behaviour and on row open refusal
  logic quiet;
  logic same;
  sdram_pkg::bank_state_t burst_halt;
  assign quiet = cmd.kind == sdram_pkg::CMD_NOP ||
                 cmd.kind == sdram_pkg::CMD_DESELECT;
  assign same = cmd.bank == beat_bank_out;
  assign burst_halt = state[beat_bank_out];

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);

  read_continue_a: assert property (
    burst_halt == sdram_pkg::ST_READ && left != 4'h0 && quiet
    |=> read_beat_out && beat_col_out == $past(beat_col_out) + `COL_W'(1))
    else $error("read burst stalled on idle command");
  read_end_a: assert property (
    burst_halt == sdram_pkg::ST_READ && left == 4'h0 && quiet
    |=> burst_halt == sdram_pkg::ST_ROW_ACTIVE)
    else $error("read burst did not return to row active");
  read_halt_a: assert property (
    burst_halt == sdram_pkg::ST_READ && cmd.kind == sdram_pkg::CMD_HALT
    |=> burst_halt == sdram_pkg::ST_ROW_ACTIVE && !read_beat_out)
    else $error("halt did not end read burst");
  read_restart_a: assert property (
    burst_halt == sdram_pkg::ST_READ && cmd.kind == sdram_pkg::CMD_READ && same
    |=> read_beat_out && beat_col_out == $past(col_in)
        ##1 read_beat_out [*3])
    else $error("read did not restart at new column");
  read_to_write_a: assert property (
    burst_halt == sdram_pkg::ST_READ && cmd.kind == sdram_pkg::CMD_WRITE && same
    |=> burst_halt == sdram_pkg::ST_WRITE && write_beat_out && !read_beat_out)
    else $error("write did not replace read burst");
  read_close_a: assert property (
    burst_halt == sdram_pkg::ST_READ && cmd.kind == sdram_pkg::CMD_CLOSE && same
    |=> burst_halt == sdram_pkg::ST_PRECHARGE && !read_beat_out)
    else $error("close did not stop read");
  write_end_a: assert property (
    burst_halt == sdram_pkg::ST_WRITE && left == 4'h0 && quiet
    |=> burst_halt == sdram_pkg::ST_WRITE_RECOVERY)
    else $error("write burst did not enter recovery");
  write_halt_a: assert property (
    burst_halt == sdram_pkg::ST_WRITE && cmd.kind == sdram_pkg::CMD_HALT
    |=> burst_halt == sdram_pkg::ST_ROW_ACTIVE && !write_beat_out)
    else $error("halt did not end write burst");
  write_to_read_a: assert property (
    burst_halt == sdram_pkg::ST_WRITE && cmd.kind == sdram_pkg::CMD_READ && same
    |=> burst_halt == sdram_pkg::ST_READ && read_beat_out)
    else $error("read did not replace write burst");
  write_restart_a: assert property (
    burst_halt == sdram_pkg::ST_WRITE && cmd.kind == sdram_pkg::CMD_WRITE && same
    |=> write_beat_out && beat_col_out == $past(col_in))
    else $error("write did not restart at new column");
  write_close_all_a: assert property (
    burst_halt == sdram_pkg::ST_WRITE && cmd.kind == sdram_pkg::CMD_CLOSE_ALL
    |=> burst_halt == sdram_pkg::ST_PRECHARGE && !write_beat_out)
    else $error("close all did not stop write");
  autoclose_end_a: assert property (
    burst_halt == sdram_pkg::ST_READ_AC && left == 4'h0 && quiet
    |=> burst_halt == sdram_pkg::ST_PRECHARGE)
    else $error("auto-close read did not precharge");
  autoclose_guard_a: assert property (
    burst_halt == sdram_pkg::ST_READ_AC && cmd.kind == sdram_pkg::CMD_HALT
    |=> illegal_out && burst_halt != sdram_pkg::ST_ROW_ACTIVE)
    else $error("halt during auto-close read not refused");
  row_open_guard_a: assert property (
    state[cmd.bank] == sdram_pkg::ST_ROW_ACTIVE &&
    cmd.kind == sdram_pkg::CMD_ROW_OPEN
    |=> illegal_out)
    else $error("row open on active bank not refused");

  read_burst_c: cover property (read_beat_out [*4]);
  write_recovery_c: cover property (
    burst_halt == sdram_pkg::ST_WRITE ##1 burst_halt == sdram_pkg::ST_WRITE_RECOVERY);
  autoclose_c: cover property (
    burst_halt == sdram_pkg::ST_READ_AC ##1 burst_halt == sdram_pkg::ST_PRECHARGE);
endmodule

// ==== verilog/sdram_bank_map.svh ====
`ifndef SDRAM_BANK_MAP_SVH
`define SDRAM_BANK_MAP_SVH

// Column and burst geometry
`define COL_W 8
`define BURST_LEN 4'h4

// Timing in ns; cycle counts round up and never fall below one
`define CLK_PERIOD_NS 50
`define PRECHARGE_NS 20
`define WRITE_RECOVERY_NS 20
`define PRECHARGE_CYC \
  ((`PRECHARGE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_RECOVERY_CYC \
  ((`WRITE_RECOVERY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Row, column and write strobe pattern of each command (active low)
`define PINS_NOP 3'h7
`define PINS_HALT 3'h6
`define PINS_READ 3'h5
`define PINS_WRITE 3'h4
`define PINS_ROW_OPEN 3'h3
`define PINS_CLOSE 3'h2
`define PINS_REFRESH 3'h1
`define PINS_MODE 3'h0
`endif

// ==== verilog/sdram_pkg.sv ====
package sdram_pkg;
  // Decoded command on the pins
  typedef enum logic [3:0] {
    CMD_DESELECT = 4'h0,
    CMD_NOP = 4'h1,
    CMD_HALT = 4'h2,
    CMD_READ = 4'h3,
    CMD_READ_AC = 4'h4,
    CMD_WRITE = 4'h5,
    CMD_WRITE_AC = 4'h6,
    CMD_ROW_OPEN = 4'h7,
    CMD_CLOSE = 4'h8,
    CMD_CLOSE_ALL = 4'h9,
    CMD_REFRESH = 4'ha,
    CMD_MODE = 4'hb
  } cmd_kind_t;

  // State of one bank
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ROW_ACTIVE = 3'h1,
    ST_READ = 3'h2,
    ST_WRITE = 3'h3,
    ST_READ_AC = 3'h4,
    ST_WRITE_RECOVERY = 3'h5,
    ST_PRECHARGE = 3'h6
  } bank_state_t;
endpackage

// ==== verilog/cmd_if.sv ====
`include "sdram_bank_map.svh"
interface cmd_if;
  sdram_pkg::cmd_kind_t kind;
  logic bank;
  logic [`COL_W-1:0] col;
  modport dec (output kind, output bank, output col);
  modport fsm (input kind, input bank, input col);
endinterface

// ==== verilog/cmd_decode.sv ====
`include "sdram_bank_map.svh"
module cmd_decode (
  // Command pins
  input wire logic cs_n_in,
  input wire logic ras_n_in,
  input wire logic cas_n_in,
  input wire logic we_n_in,
  input wire logic bank_sel_in,
  input wire logic a10_in,
  input wire logic [`COL_W-1:0] col_in,
  // Decoded command
  cmd_if.dec bus
);
  // Bank and column lines pass straight through; the strobes and a10 need decoding
  assign bus.bank = bank_sel_in;
  assign bus.col = col_in;

  // Strobe pattern to command; a10 picks auto-close or both banks
  always_comb begin
    bus.kind = sdram_pkg::CMD_DESELECT;
    if (!cs_n_in) begin
      case ({ras_n_in, cas_n_in, we_n_in})
        `PINS_NOP: bus.kind = sdram_pkg::CMD_NOP;
        `PINS_HALT: bus.kind = sdram_pkg::CMD_HALT;
        `PINS_READ: bus.kind = a10_in ? sdram_pkg::CMD_READ_AC
                                      : sdram_pkg::CMD_READ;
        `PINS_WRITE: bus.kind = a10_in ? sdram_pkg::CMD_WRITE_AC
                                       : sdram_pkg::CMD_WRITE;
        `PINS_ROW_OPEN: bus.kind = sdram_pkg::CMD_ROW_OPEN;
        `PINS_CLOSE: bus.kind = a10_in ? sdram_pkg::CMD_CLOSE_ALL
                                       : sdram_pkg::CMD_CLOSE;
        `PINS_REFRESH: bus.kind = sdram_pkg::CMD_REFRESH;
        `PINS_MODE: bus.kind = sdram_pkg::CMD_MODE;
        default: bus.kind = sdram_pkg::CMD_NOP;
      endcase
    end
  end
endmodule

// ==== tb/cmd_master.sv ====
`include "sdram_bank_map.svh"
module cmd_master (
  // Clock and observed bank states
  input wire logic clock_in,
  input wire sdram_pkg::bank_state_t bank0_state_in,
  input wire sdram_pkg::bank_state_t bank1_state_in,
  // Command pins: ras, cas, we as one field
  output logic cs_n_out,
  output logic [2:0] pins_out,
  output logic bank_out,
  output logic a10_out,
  output logic [`COL_W-1:0] col_out
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus at time zero: deselected
  initial begin
    cs_n_out = 1'h1;
    pins_out = `PINS_NOP;
    bank_out = 1'h0;
    a10_out = 1'h0;
    col_out = 8'h00;
  end

  // One command per rising edge; a command to a bank in auto-close read, or a row open,
  // refresh or mode load on an open row, becomes a no-op unless the caller wants to see it refused
  task automatic issue(input logic cs_n, input logic [2:0] pins,
      input logic bank, input logic a10, input logic [`COL_W-1:0] col,
      input logic bad);
    sdram_pkg::bank_state_t st;
    sdram_pkg::bank_state_t oth;
    logic hold;
    st = bank ? bank1_state_in : bank0_state_in;
    oth = bank ? bank0_state_in : bank1_state_in;
    hold = !cs_n && pins != `PINS_NOP && st == sdram_pkg::ST_READ_AC;
    hold = hold || (!cs_n && pins inside {`PINS_ROW_OPEN, `PINS_REFRESH,
        `PINS_MODE} && st inside {sdram_pkg::ST_ROW_ACTIVE,
        sdram_pkg::ST_READ, sdram_pkg::ST_WRITE});
    // Refresh and mode load act on the whole chip, so the other bank counts
    hold = hold || (!cs_n && pins inside {`PINS_REFRESH, `PINS_MODE} &&
        oth inside {sdram_pkg::ST_ROW_ACTIVE, sdram_pkg::ST_READ,
        sdram_pkg::ST_WRITE});
    if (hold && !bad) begin
      pins = `PINS_NOP;
    end
    @(posedge clock_in);
    cs_n_out <= cs_n;
    pins_out <= pins;
    bank_out <= bank;
    a10_out <= a10;
    col_out <= col;
  endtask
endmodule

// ==== tb/testbench.sv ====
`include "sdram_bank_map.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  // Clock, reset and pins
  logic clock_in;
  logic arst_n_in;
  logic cs_n;
  logic [2:0] pins;
  logic bank;
  logic a10;
  logic [`COL_W-1:0] col;
  // Observed outputs
  sdram_pkg::bank_state_t st0;
  sdram_pkg::bank_state_t st1;
  logic rd_beat;
  logic wr_beat;
  logic beat_bank;
  logic [`COL_W-1:0] beat_col;
  logic illegal;
  int err_total;
  int checked;

  cmd_master partner_u (.clock_in(clock_in), .bank0_state_in(st0),
    .bank1_state_in(st1), .cs_n_out(cs_n), .pins_out(pins),
    .bank_out(bank), .a10_out(a10), .col_out(col));

  sdram_bank_fsm dut_u (.clock_in(clock_in), .arst_n_in(arst_n_in),
    .cs_n_in(cs_n), .ras_n_in(pins[2]), .cas_n_in(pins[1]),
    .we_n_in(pins[0]), .bank_sel_in(bank), .a10_in(a10), .col_in(col),
    .bank0_state_out(st0), .bank1_state_out(st1), .read_beat_out(rd_beat),
    .write_beat_out(wr_beat), .beat_bank_out(beat_bank),
    .beat_col_out(beat_col), .illegal_out(illegal));

  // Free-running 20 MHz clock
  initial begin
    clock_in = 1'h0;
    forever #25 clock_in = ~clock_in;
  end

  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Shared tally; wrappers keep each kind of result typed
  task automatic tally(input logic miss, input logic [7:0] got, exp);
    checked++;
    if (miss) begin
      err_total++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_st(input sdram_pkg::bank_state_t got, exp);
    tally(got !== exp, 8'(got), 8'(exp));
  endtask
  task automatic chk_b(input logic got, exp);
    tally(got !== exp, 8'(got), 8'(exp));
  endtask
  task automatic chk_c(input logic [7:0] got, exp);
    tally(got !== exp, got, exp);
  endtask

  // One command cycle; outputs are read at the falling edge, settled
  task automatic cyc(input logic [2:0] p, input logic b, input logic a,
      input logic [7:0] c, input logic bad);
    partner_u.issue(1'h0, p, b, a, c, bad);
    @(negedge clock_in);
  endtask
  task automatic nop();
    cyc(`PINS_NOP, 1'h0, 1'h0, 8'h00, 1'h0);
  endtask
  // Deselect with junk on the strobes, which must be ignored
  task automatic chip_deselect();
    partner_u.issue(1'h1, `PINS_HALT, 1'h1, 1'h1, 8'haa, 1'h0);
    @(negedge clock_in);
  endtask
  task automatic beat(input logic r, w, input logic [7:0] c);
    chk_b(rd_beat, r);
    chk_b(wr_beat, w);
    chk_c(beat_col, c);
  endtask

  // Read across the column wrap, fed by deselects
  task automatic t_read_run();
    cyc(`PINS_READ, 1'h0, 1'h0, 8'hfe, 1'h0);
    for (int i = 0; i < 4; i++) begin
      chip_deselect();
      chk_st(st0, sdram_pkg::ST_READ);
      beat(1'h1, 1'h0, 8'hfe + 8'(i));
    end
    nop();
    chk_st(st0, sdram_pkg::ST_ROW_ACTIVE);
    chk_b(rd_beat, 1'h0);
    $display("test read_run done");
  endtask

  // Write burst, one recovery cycle, then row active
  task automatic t_write_run();
    cyc(`PINS_WRITE, 1'h0, 1'h0, 8'h80, 1'h0);
    for (int i = 0; i < 4; i++) begin
      nop();
      beat(1'h0, 1'h1, 8'h80 + 8'(i));
    end
    nop();
    chk_st(st0, sdram_pkg::ST_WRITE_RECOVERY);
    chk_b(wr_beat, 1'h0);
    nop();
    chk_st(st0, sdram_pkg::ST_ROW_ACTIVE);
    $display("test write_run done");
  endtask

  // Halt in the second beat of a read or write burst
  task automatic t_halt(input logic [2:0] p);
    cyc(p, 1'h0, 1'h0, 8'h20, 1'h0);
    nop();
    cyc(`PINS_HALT, 1'h0, 1'h0, 8'h00, 1'h0);
    nop();
    chk_st(st0, sdram_pkg::ST_ROW_ACTIVE);
    chk_b(rd_beat | wr_beat, 1'h0);
    $display("test halt done");
  endtask

  // Back-to-back column command cuts the burst and restarts at new column
  task automatic t_switch(input logic [2:0] p, q, input logic a);
    logic w;
    w = q == `PINS_WRITE;
    cyc(p, 1'h0, 1'h0, 8'h30, 1'h0);
    nop();
    cyc(q, 1'h0, a, 8'h40, 1'h0);
    nop();
    chk_st(st0, w ? sdram_pkg::ST_WRITE : a ? sdram_pkg::ST_READ_AC :
        sdram_pkg::ST_READ);
    beat(!w, w, 8'h40);
    repeat (7) nop();
    chk_st(st0, a ? sdram_pkg::ST_IDLE :
        sdram_pkg::ST_ROW_ACTIVE);
    if (a) begin
      cyc(`PINS_ROW_OPEN, 1'h0, 1'h0, 8'h00, 1'h0);
    end
    $display("test switch done");
  endtask

  // Close one bank or both in mid-burst
  task automatic t_close(input logic [2:0] p, input logic all);
    cyc(p, 1'h0, 1'h0, 8'h50, 1'h0);
    nop();
    cyc(`PINS_CLOSE, 1'h0, all, 8'h00, 1'h0);
    nop();
    chk_st(st0, sdram_pkg::ST_PRECHARGE);
    chk_st(st1, all ? sdram_pkg::ST_PRECHARGE :
        sdram_pkg::ST_ROW_ACTIVE);
    chk_b(rd_beat | wr_beat, 1'h0);
    nop();
    chk_st(st0, sdram_pkg::ST_IDLE);
    cyc(`PINS_ROW_OPEN, 1'h0, 1'h0, 8'h00, 1'h0);
    cyc(`PINS_ROW_OPEN, 1'h1, 1'h0, 8'h00, 1'h0);
    nop();
    $display("test close done");
  endtask

  // Auto-close read refuses a halt, runs out, precharges itself
  task automatic t_autoclose();
    cyc(`PINS_READ, 1'h0, 1'h1, 8'h90, 1'h0);
    nop();
    chk_st(st0, sdram_pkg::ST_READ_AC);
    cyc(`PINS_HALT, 1'h0, 1'h0, 8'h00, 1'h1);
    nop();
    chk_b(illegal, 1'h1);
    beat(1'h1, 1'h0, 8'h92);
    nop();
    nop();
    chk_st(st0, sdram_pkg::ST_PRECHARGE);
    nop();
    chk_st(st0, sdram_pkg::ST_IDLE);
    cyc(`PINS_ROW_OPEN, 1'h0, 1'h0, 8'h00, 1'h0);
    $display("test autoclose done");
  endtask

  // Row open on an active bank: refused when sent, withheld otherwise
  task automatic t_forbid();
    cyc(`PINS_ROW_OPEN, 1'h1, 1'h0, 8'h00, 1'h1);
    nop();
    chk_b(illegal, 1'h1);
    chk_st(st1, sdram_pkg::ST_ROW_ACTIVE);
    cyc(`PINS_ROW_OPEN, 1'h1, 1'h0, 8'h00, 1'h0);
    nop();
    chk_b(illegal, 1'h0);
    $display("test forbid done");
  endtask

  // Burst on bank 1, then a read on bank 0 takes the data bus over;
  // refresh and mode load with rows open are refused
  task automatic t_other();
    cyc(`PINS_READ, 1'h1, 1'h0, 8'h60, 1'h0);
    nop();
    chk_st(st1, sdram_pkg::ST_READ);
    chk_b(beat_bank, 1'h1);
    beat(1'h1, 1'h0, 8'h60);
    cyc(`PINS_READ, 1'h0, 1'h0, 8'h70, 1'h0);
    nop();
    chk_st(st1, sdram_pkg::ST_ROW_ACTIVE);
    chk_st(st0, sdram_pkg::ST_READ);
    chk_b(beat_bank, 1'h0);
    beat(1'h1, 1'h0, 8'h70);
    repeat (4) nop();
    chk_st(st0, sdram_pkg::ST_ROW_ACTIVE);
    cyc(`PINS_REFRESH, 1'h0, 1'h0, 8'h00, 1'h1);
    cyc(`PINS_MODE, 1'h0, 1'h0, 8'h00, 1'h1);
    chk_b(illegal, 1'h1);
    nop();
    chk_b(illegal, 1'h1);
    chk_st(st0, sdram_pkg::ST_ROW_ACTIVE);
    chk_st(st1, sdram_pkg::ST_ROW_ACTIVE);
    $display("test other done");
  endtask

  // Main sequence
  initial begin
    err_total = 0;
    checked = 0;
    arst_n_in = 1'h0;
    repeat (3) @(posedge clock_in);
    arst_n_in <= 1'h1;
    @(negedge clock_in);
    cyc(`PINS_ROW_OPEN, 1'h0, 1'h0, 8'h00, 1'h0);
    cyc(`PINS_ROW_OPEN, 1'h1, 1'h0, 8'h00, 1'h0);
    nop();
    t_read_run();
    t_write_run();
    t_halt(`PINS_READ);
    t_halt(`PINS_WRITE);
    for (int k = 0; k < 8; k++) begin
      t_switch(k[2] ? `PINS_WRITE : `PINS_READ,
          k[1] ? `PINS_WRITE : `PINS_READ, k[0]);
    end
    for (int k = 0; k < 4; k++) begin
      t_close(k[1] ? `PINS_WRITE : `PINS_READ, k[0]);
    end
    t_autoclose();
    t_forbid();
    t_other();
    report_and_stop();
  end

  // Watchdog: the tests take under two hundred cycles
  initial begin
    #(3000 * 50);
    err_total++;
    report_and_stop();
  end
endmodule
